// File: sdb_consts.vh
/*
 * Constants of the serial data register and rate generator: register
 * offsets, field positions, reset values and divider figures.
 * Assumes it is included by bare name into the design file only.
 */
// Behaviour
// - One address: write transmit, read receive holder.
// - Transmit holder feeds output shift register parallel.
// - Receive holder takes shift register character parallel.
// - First prescale code selects 1, 3, 4, 13.
// - Transmit divide code selects two to code.
// - Receive divide code selects two to code.
// - Conventional transmit rate: clock over prescale times divisor.
// - Conventional receive rate: clock over prescale times divisor.
// - Nonzero receive extended value divides sixteen-stage output.
// - Nonzero transmit extended value divides sixteen-stage output.
// - Extended dividers inactive after reset.
`ifndef SDB_CONSTS_VH
`define SDB_CONSTS_VH

// Register bus.
`define SDB_ADDR_W          2
`define SDB_DATA_W          8
`define SDB_OFS_DATA        2'h0
`define SDB_OFS_RATE        2'h1
`define SDB_OFS_RX_EXT      2'h2
`define SDB_OFS_TX_EXT      2'h3

// Reset values.
`define SDB_RST_DATA        8'h00
`define SDB_RST_RATE        8'h00
`define SDB_RST_EXT         8'h00

// Fields of rate_select.
`define SDB_PRE_HI          7
`define SDB_PRE_LO          6
`define SDB_TXDIV_HI        5
`define SDB_TXDIV_LO        3
`define SDB_RXDIV_HI        2
`define SDB_RXDIV_LO        0

// First prescale codes and the terminal counts they select (factor - 1).
`define SDB_PRE_CODE_1      2'h0
`define SDB_PRE_CODE_3      2'h1
`define SDB_PRE_CODE_4      2'h2
`define SDB_PRE_CODE_13     2'h3
`define SDB_PRE_TC_1        4'h0
`define SDB_PRE_TC_3        4'h2
`define SDB_PRE_TC_4        4'h3
`define SDB_PRE_TC_13       4'hC
`define SDB_PRE_W           4

// Direction divisor counter, up to 128.
`define SDB_DIV_W           7
`define SDB_DIV_ONE         7'h01

// Fixed divide-by-16 stage.
`define SDB_SIXTEEN_W       4
`define SDB_SIXTEEN_TC      4'hF

// Extended divider.
`define SDB_EXT_ZERO        8'h00
`define SDB_EXT_ONE         8'h01

`endif

// File: sdb_data_baud.v
/*
 * Data holding registers and rate generator of an asynchronous serial
 * interface. Holds the transmit and receive character holders behind one
 * address and makes per-direction oversample and bit-rate enable pulses.
 * Assumes the shift registers, framing and status logic sit elsewhere on
 * the same clock, and a bus master that follows the one-cycle strobe bus.
 */
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "sdb_consts.vh"

module sdb_data_baud (
	// Clock and reset.
	input  wire                    i_clk,
	input  wire                    i_rst_b,
	// Register bus.
	input  wire [`SDB_ADDR_W-1:0]  i_addr,
	input  wire [`SDB_DATA_W-1:0]  i_wr_data,
	input  wire                    i_wr,
	input  wire                    i_rd,
	output reg  [`SDB_DATA_W-1:0]  o_rd_data,
	// Transmit shift register side.
	output reg  [`SDB_DATA_W-1:0]  o_tx_data,
	output reg                     o_tx_full,
	input  wire                    i_tx_load,
	// Receive shift register side.
	input  wire [`SDB_DATA_W-1:0]  i_rx_data,
	input  wire                    i_rx_valid,
	output reg                     o_rx_read,
	// Rate enables: index 0 transmit, index 1 receive.
	output reg  [1:0]              o_sample_tick,
	output reg  [1:0]              o_bit_tick
);

	// Terminal count of the first prescaler for a code.
	function [`SDB_PRE_W-1:0] pre_tc;
		input [1:0] code;
		begin
			case (code)
				`SDB_PRE_CODE_1:  pre_tc = `SDB_PRE_TC_1;
				`SDB_PRE_CODE_3:  pre_tc = `SDB_PRE_TC_3;
				`SDB_PRE_CODE_4:  pre_tc = `SDB_PRE_TC_4;
				`SDB_PRE_CODE_13: pre_tc = `SDB_PRE_TC_13;
				default:          pre_tc = `SDB_PRE_TC_1;
			endcase
		end
	endfunction

	// Terminal count of a direction divisor: two to the code, minus one.
	function [`SDB_DIV_W-1:0] div_tc;
		input [2:0] code;
		begin
			div_tc = (`SDB_DIV_ONE << code) - `SDB_DIV_ONE;
		end
	endfunction

	reg  [`SDB_DATA_W-1:0]  transmit_holder;
	reg  [`SDB_DATA_W-1:0]  receive_holder;
	reg  [`SDB_DATA_W-1:0]  rate_select;
	reg  [`SDB_DATA_W-1:0]  receive_extended_divider;
	reg  [`SDB_DATA_W-1:0]  transmit_extended_divider;
	reg  [`SDB_PRE_W-1:0]   pre_cnt;
	reg                     pre_tick;
	reg  [`SDB_DATA_W-1:0]  next_rd_data;

	wire [1:0]              first_prescale_code;
	wire [2:0]              transmit_divide_code;
	wire [2:0]              receive_divide_code;
	wire [2:0]              divide_code [0:1];
	wire [`SDB_DATA_W-1:0]  extended_value [0:1];

	assign first_prescale_code  = rate_select[`SDB_PRE_HI:`SDB_PRE_LO];
	assign transmit_divide_code = rate_select[`SDB_TXDIV_HI:`SDB_TXDIV_LO];
	assign receive_divide_code  = rate_select[`SDB_RXDIV_HI:`SDB_RXDIV_LO];
	assign divide_code[0]       = transmit_divide_code;
	assign divide_code[1]       = receive_divide_code;
	assign extended_value[0]    = transmit_extended_divider;
	assign extended_value[1]    = receive_extended_divider;

	// Register writes share one address for the character holders.
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			transmit_holder           <= `SDB_RST_DATA;
			rate_select               <= `SDB_RST_RATE;
			receive_extended_divider  <= `SDB_RST_EXT;
			transmit_extended_divider <= `SDB_RST_EXT;
		end else if (i_wr) begin
			case (i_addr)
				`SDB_OFS_DATA:   transmit_holder           <= i_wr_data;
				`SDB_OFS_RATE:   rate_select               <= i_wr_data;
				`SDB_OFS_RX_EXT: receive_extended_divider  <= i_wr_data;
				`SDB_OFS_TX_EXT: transmit_extended_divider <= i_wr_data;
				default:         rate_select               <= rate_select;
			endcase
		end
	end

	// A character written while the shift register loads the previous one
	// keeps the holder full, so the new write is never lost.
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_tx_full <= 1'b0;
			o_tx_data <= `SDB_RST_DATA;
		end else begin
			if (i_wr && i_addr == `SDB_OFS_DATA) begin
				o_tx_full <= 1'b1;
				o_tx_data <= i_wr_data;
			end else if (i_tx_load) begin
				o_tx_full <= 1'b0;
			end
		end
	end

	// The receive holder captures each assembled character in one cycle.
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			receive_holder <= `SDB_RST_DATA;
		end else if (i_rx_valid) begin
			receive_holder <= i_rx_data;
		end
	end

	// Read decode; unmapped addresses cannot occur with a two-bit address.
	always @* begin
		case (i_addr)
			`SDB_OFS_DATA:   next_rd_data = receive_holder;
			`SDB_OFS_RATE:   next_rd_data = rate_select;
			`SDB_OFS_RX_EXT: next_rd_data = receive_extended_divider;
			`SDB_OFS_TX_EXT: next_rd_data = transmit_extended_divider;
			default:         next_rd_data = `SDB_RST_DATA;
		endcase
	end

	// Read data stand only in the cycle after the strobe; zero otherwise.
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data <= `SDB_RST_DATA;
			o_rx_read <= 1'b0;
		end else begin
			o_rd_data <= i_rd ? next_rd_data : `SDB_RST_DATA;
			o_rx_read <= i_rd && (i_addr == `SDB_OFS_DATA);
		end
	end

	// First prescaler shared by both directions. The compare uses >= so a
	// code change that lowers the terminal count cannot strand the counter.
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pre_cnt  <= {`SDB_PRE_W{1'b0}};
			pre_tick <= 1'b0;
		end else if (pre_cnt >= pre_tc(first_prescale_code)) begin
			pre_cnt  <= {`SDB_PRE_W{1'b0}};
			pre_tick <= 1'b1;
		end else begin
			pre_cnt  <= pre_cnt + {{(`SDB_PRE_W-1){1'b0}}, 1'b1};
			pre_tick <= 1'b0;
		end
	end

	// Per direction: divisor, fixed divide-by-16, then optional extended
	// divider. The sample tick runs at the conventional rate clock; the bit
	// tick is the line rate.
	genvar d;
	generate
		for (d = 0; d < 2; d = d + 1) begin : g_dir
			reg  [`SDB_DIV_W-1:0]     div_cnt;
			reg  [`SDB_SIXTEEN_W-1:0] six_cnt;
			reg  [`SDB_DATA_W-1:0]    ext_cnt;
			wire                      div_end;
			wire                      six_end;
			wire                      ext_on;
			wire                      ext_end;

			assign div_end = pre_tick && (div_cnt >= div_tc(divide_code[d]));
			assign six_end = div_end && (six_cnt == `SDB_SIXTEEN_TC);
			assign ext_on  = extended_value[d] != `SDB_EXT_ZERO;
			assign ext_end = !ext_on || (ext_cnt >= extended_value[d] - `SDB_EXT_ONE);

			always @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					div_cnt <= {`SDB_DIV_W{1'b0}};
				end else if (div_end) begin
					div_cnt <= {`SDB_DIV_W{1'b0}};
				end else if (pre_tick) begin
					div_cnt <= div_cnt + `SDB_DIV_ONE;
				end
			end

			always @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					six_cnt <= {`SDB_SIXTEEN_W{1'b0}};
				end else if (div_end) begin
					six_cnt <= six_cnt + {{(`SDB_SIXTEEN_W-1){1'b0}}, 1'b1};
				end
			end

			// A zero value holds the counter at zero so that the extended
			// stage passes each sixteen-stage pulse straight through.
			always @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					ext_cnt <= `SDB_EXT_ZERO;
				end else if (!ext_on) begin
					ext_cnt <= `SDB_EXT_ZERO;
				end else if (six_end) begin
					ext_cnt <= ext_end ? `SDB_EXT_ZERO : ext_cnt + `SDB_EXT_ONE;
				end
			end

			always @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					o_sample_tick[d] <= 1'b0;
					o_bit_tick[d]    <= 1'b0;
				end else begin
					o_sample_tick[d] <= div_end;
					o_bit_tick[d]    <= six_end && ext_end;
				end
			end
		end
	endgenerate

endmodule // sdb_data_baud

// File: sdb_data_baud_assertions.sv
/* Port checker of the data holders and rate generator.
   Assumes one clock and the active-low asynchronous reset of the block. */
`timescale 1ns/1ps
module sdb_data_baud_chk (
	// Clock, reset and register bus.
	input logic       i_clk,
	input logic       i_rst_b,
	input logic [1:0] i_addr,
	input logic [7:0] i_wr_data,
	input logic       i_wr,
	input logic       i_rd,
	input logic [7:0] o_rd_data,
	// Shift register side and ticks.
	input logic [7:0] o_tx_data,
	input logic       o_tx_full,
	input logic       i_tx_load,
	input logic [7:0] i_rx_data,
	input logic       i_rx_valid,
	input logic       o_rx_read,
	input logic [1:0] o_sample_tick,
	input logic [1:0] o_bit_tick
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	a_rd_idle_zero: assert property (!$past(i_rd) |-> o_rd_data == 8'h00)
		else $error("read data not zero outside a read");
	a_rx_read_pulse: assert property (o_rx_read == $past(i_rd && i_addr == 2'h0))
		else $error("receive read pulse mistimed");
	a_tx_write_load: assert property (i_wr && i_addr == 2'h0 |=> o_tx_full && o_tx_data == $past(i_wr_data))
		else $error("write did not fill the transmit holder");
	a_tx_load_clear: assert property (i_tx_load && !(i_wr && i_addr == 2'h0) |=> !o_tx_full)
		else $error("transmit full not cleared by load");
	a_tx_full_hold: assert property (o_tx_full && !i_tx_load |=> o_tx_full)
		else $error("transmit full dropped without load");
	a_rd_rx_char: assert property (i_rx_valid ##1 (i_rd && i_addr == 2'h0 && !i_rx_valid)
		|=> o_rd_data == $past(i_rx_data, 2))
		else $error("received character not returned");
	a_bit_on_sample: assert property ((o_bit_tick & ~o_sample_tick) == 2'b00)
		else $error("bit tick without sample tick");
	a_bit_tick_gap: assert property (o_bit_tick != 2'b00 |=> (o_bit_tick & $past(o_bit_tick)) == 2'b00)
		else $error("bit tick longer than one cycle");
endmodule // sdb_data_baud_chk

bind sdb_data_baud sdb_data_baud_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
	.i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_tx_data(o_tx_data),
	.o_tx_full(o_tx_full), .i_tx_load(i_tx_load), .i_rx_data(i_rx_data), .i_rx_valid(i_rx_valid),
	.o_rx_read(o_rx_read), .o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick));

// File: sdb_line_partner.sv
/* Line side model: takes the transmit character on a transmit bit tick
   and hands it back as received on a later receive bit tick. */
`timescale 1ns/1ps
module sdb_line_partner (
	// Clock, reset and ticks.
	input  logic       i_clk,
	input  logic       i_rst_b,
	input  logic [1:0] i_bit_tick,
	// Transmit and receive sides.
	input  logic       i_tx_full,
	input  logic [7:0] i_tx_data,
	output logic       o_tx_load = 1'b0,
	output logic [7:0] o_rx_data = 8'h00,
	output logic       o_rx_valid = 1'b0
);
	logic [7:0] held = 8'h00;
	logic       pend = 1'b0;
	// Data toggles outside the valid cycle so a stale read cannot match.
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{held, pend, o_tx_load, o_rx_valid} <= '0;
		end else begin
			o_tx_load <= i_tx_full && i_bit_tick[0] && !o_tx_load && !pend;
			o_rx_valid <= pend && i_bit_tick[1];
			o_rx_data <= (pend && i_bit_tick[1]) ? held : ~o_rx_data;
			if (o_tx_load)
				{held, pend} <= {i_tx_data, 1'b1};
			else if (o_rx_valid)
				pend <= 1'b0;
		end
	end
endmodule // sdb_line_partner

// File: sdb_data_baud_tb.sv
/* Testbench of the data holders and rate generator: bus tasks, tick periods
   and a looped character. Assumes the line partner model and the checker. */
`timescale 1ns/1ps
module sdb_data_baud_tb;
	logic       i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0;
	logic [1:0] i_addr = 2'h0;
	logic [7:0] i_wr_data = 8'h00, o_rd_data, o_tx_data, i_rx_data, r;
	logic       o_tx_full, i_tx_load, i_rx_valid, o_rx_read;
	logic [1:0] o_sample_tick, o_bit_tick;
	int         bad_count = 0, cmp_count = 0, n, p;
	int         pf[4] = '{1, 3, 4, 13};
	wire  [3:0] tk = {o_bit_tick, o_sample_tick};
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("unexpected %0t %0h/%0h", $time, a, b); end end
	sdb_data_baud u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data),
		.i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .o_tx_data(o_tx_data), .o_tx_full(o_tx_full),
		.i_tx_load(i_tx_load), .i_rx_data(i_rx_data), .i_rx_valid(i_rx_valid), .o_rx_read(o_rx_read),
		.o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick));
	sdb_line_partner u_far (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bit_tick(o_bit_tick), .i_tx_full(o_tx_full),
		.i_tx_data(o_tx_data), .o_tx_load(i_tx_load), .o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid));
	initial forever #12.5 i_clk = ~i_clk;
	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		{i_wr, i_addr, i_wr_data} <= {1'b1, a, d};
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [1:0] a);
		@(posedge i_clk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 r = o_rd_data;
	endtask
	// The first period after a rate change may be short, so the third tick is timed.
	task per(input int k);
		int i, c;
		c = 0;
		n = 0;
		for (i = 0; i < 20000 && c < 3; i++) begin
			@(posedge i_clk);
			#1 n += (c == 2);
			c += tk[k];
		end
		if (c < 3) begin
			bad_count++;
			test_done;
		end
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (p = 0; p < 4; p++) begin
			rd(p[1:0]);
			`CK(r, 8'h00)
		end
		per(2);
		`CK(n, 16)
		for (p = 0; p < 4; p++) begin
			wr(2'h1, {p[1:0], 6'h0A});
			per(0);
			`CK(n, pf[p] * 2)
			per(1);
			`CK(n, pf[p] * 4)
		end
		wr(2'h1, 8'h38);
		per(0);
		`CK(n, 128)
		per(3);
		`CK(n, 16)
		wr(2'h3, 8'h03);
		wr(2'h2, 8'hFF);
		per(2);
		`CK(n, 6144)
		per(3);
		`CK(n, 4080)
		wr(2'h3, 8'h00);
		per(2);
		`CK(n, 2048)
		wr(2'h2, 8'h00);
		wr(2'h1, 8'h00);
		wr(2'h0, 8'hA5);
		#1 `CK(o_tx_data, 8'hA5)
		for (p = 0; p < 200 && i_rx_valid !== 1'b1; p++) begin
			@(posedge i_clk);
			#1;
		end
		if (p == 200) begin
			bad_count++;
			test_done;
		end
		`CK(o_tx_full, 1'b0)
		rd(2'h0);
		`CK(r, 8'hA5)
		`CK(o_rx_read, 1'b1)
		test_done;
	end
endmodule // sdb_data_baud_tb
